// ==== rtl/mbam_top.sv ====
// Modbus slave address mapper with APB configuration registers
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - Highest remote index ranges one to hundred
// - Remotes above highest index are never served in address mode
// - Highest remote index resets to one
// - Serial rate resets to 19200 baud
// - Register mode station address 1 to 247
// - Address mode ceiling 247 minus remotes
// - Address mode remote at station plus index
// - Register mode answers only station address
// - Station address resets to one
// - Parity gives one stop, none two
// - Parity resets to even
// - Address mode: ten registers per address
// - Register mode: blocks of ten per unit
// - Mapping mode resets to address mapping
// - Only binary framing, ASCII frames refused
// - Five serial rates, eight data bits
// - Unmapped register read gives exception two
module mbam_top (
  input wire logic I_CLK,              // 100 MHz clock
  input wire logic I_NRST,             // Async reset, active low
  input wire logic I_PSEL,             // APB select
  input wire logic I_PENABLE,          // APB access phase
  input wire logic I_PWRITE,           // APB write
  input wire logic [11:0] I_PADDR,     // APB byte address
  input wire logic [31:0] I_PWDATA,    // APB write data
  output logic [31:0] O_PRDATA,        // APB read data
  output logic O_PREADY,               // APB ready
  output logic O_PSLVERR,              // APB error
  input wire logic I_FRM_VALID,        // Parsed frame strobe
  input wire logic [7:0] I_FRM_ADDR,   // Frame slave address
  input wire logic [7:0] I_FRM_FUNC,   // Frame function code
  input wire logic [15:0] I_FRM_REG,   // First register number
  input wire logic [15:0] I_FRM_QTY,   // Register count
  input wire logic I_FRM_ASCII,        // Frame was ASCII framed
  output logic O_RSP_VALID,            // Frame accepted pulse
  output logic O_RSP_DROP,             // Frame ignored pulse
  output logic [6:0] O_RSP_UNIT,       // Unit addressed
  output logic [3:0] O_RSP_OFFS,       // First register offset
  output logic [7:0] O_RSP_EXC,        // Exception code
  output logic [15:0] O_BIT_DIV,       // Clocks per serial bit
  output logic [3:0] O_DATA_BITS,      // Data bits per character
  output logic O_PARITY_EN,            // Parity bit present
  output logic O_PARITY_ODD,           // Odd parity when enabled
  output logic O_STOP_TWO              // Two stop bits
);
  // ----------------------------------------------------------------
  // Settings
  // ----------------------------------------------------------------
  logic [6:0] hi_ff;
  logic [7:0] sid_ff;
  logic [2:0] baud_ff;
  mbam_pkg::mbam_par_t par_ff;
  mbam_pkg::mbam_map_t mode_ff;
  logic rej_ff;
  logic [2:0] why_ff;
  logic [15:0] served_ff;
  logic [15:0] dropped_ff;
  logic [31:0] rdata_ff;
  logic ready_ff;
  logic err_ff;

  mbam_cfg_if live_if ();
  mbam_cfg_if cand_if ();

  assign live_if.highest_remote_index = hi_ff;
  assign live_if.station_address = sid_ff;
  assign live_if.map_mode_select = mode_ff;

  assign cand_if.highest_remote_index = I_PWDATA[mbam_pkg::CFG_HI_LSB +: 7];
  assign cand_if.station_address = I_PWDATA[mbam_pkg::CFG_SID_LSB +: 8];
  assign cand_if.map_mode_select =
    mbam_pkg::mbam_map_t'(I_PWDATA[mbam_pkg::CFG_MODE_BIT]);

  wire cand_ok;
  wire [2:0] cand_why;

  mbam_cfg_check u_check (
    .cand(cand_if.dst),
    .i_baud(I_PWDATA[mbam_pkg::CFG_BAUD_LSB +: 3]),
    .i_par(I_PWDATA[mbam_pkg::CFG_PAR_LSB +: 2]),
    .o_ok(cand_ok),
    .o_why(cand_why)
  );

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire setup = I_PSEL && !I_PENABLE;
  wire commit = I_PSEL && I_PENABLE && ready_ff;
  wire hit_cfg = I_PADDR == mbam_pkg::ADDR_CFG;
  wire hit_stat = I_PADDR == mbam_pkg::ADDR_STAT;
  wire hit_served = I_PADDR == mbam_pkg::ADDR_SERVED;
  wire hit_dropped = I_PADDR == mbam_pkg::ADDR_DROPPED;
  wire mapped = hit_cfg || hit_stat || hit_served || hit_dropped;
  // Counters are read only; a write to them is an error
  wire ro_write = I_PWRITE && (hit_served || hit_dropped);
  wire cfg_bad = I_PWRITE && hit_cfg && !cand_ok;
  wire nxt_err = !mapped || ro_write || cfg_bad;
  wire cfg_wr = commit && I_PWRITE && hit_cfg && !err_ff;
  wire cfg_rej = commit && I_PWRITE && hit_cfg && err_ff;
  wire stat_clr = commit && I_PWRITE && hit_stat &&
                  I_PWDATA[mbam_pkg::STAT_REJ_BIT];
  wire [7:0] ceil = mbam_pkg::SID_MAX - {1'b0, hi_ff};

  wire [31:0] cfg_word = {7'h00, mode_ff, 2'b00, par_ff, 1'b0, baud_ff,
                          sid_ff, 1'b0, hi_ff};
  wire [31:0] stat_word = {16'h0000, ceil, 1'b0, why_ff, 3'b000, rej_ff};
  wire [31:0] nxt_rdata = I_PWRITE ? 32'h0000_0000 :
                          hit_cfg ? cfg_word :
                          hit_stat ? stat_word :
                          hit_served ? {16'h0000, served_ff} :
                          hit_dropped ? {16'h0000, dropped_ff} :
                          32'h0000_0000;

  // Zero wait states: ready rises in the first access cycle
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      ready_ff <= 1'b0;
      err_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end else begin
      ready_ff <= setup;
      err_ff <= setup && nxt_err;
      rdata_ff <= setup ? nxt_rdata : 32'h0000_0000;
    end
  end

  // Illegal settings are refused whole; the old set stays in force
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      hi_ff <= mbam_pkg::RST_HI;
      sid_ff <= mbam_pkg::RST_SID;
      baud_ff <= mbam_pkg::RST_BAUD;
      par_ff <= mbam_pkg::MBAM_PAR_EVEN;
      mode_ff <= mbam_pkg::MBAM_MAP_ADDR;
    end else if (cfg_wr) begin
      hi_ff <= cand_if.highest_remote_index;
      sid_ff <= cand_if.station_address;
      baud_ff <= I_PWDATA[mbam_pkg::CFG_BAUD_LSB +: 3];
      par_ff <= mbam_pkg::mbam_par_t'(I_PWDATA[mbam_pkg::CFG_PAR_LSB +: 2]);
      mode_ff <= cand_if.map_mode_select;
    end
  end

  // A refusal arriving with a clear still sets the flag
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      rej_ff <= 1'b0;
      why_ff <= mbam_pkg::WHY_OK;
    end else begin
      rej_ff <= cfg_rej || (rej_ff && !stat_clr);
      if (cfg_rej) begin
        why_ff <= cand_why;
      end
    end
  end

  // ----------------------------------------------------------------
  // Frame resolution
  // ----------------------------------------------------------------
  wire frm_hit;
  wire frm_range_ok;
  wire [6:0] frm_unit;
  wire [3:0] frm_offs;
  wire [7:0] frm_exc;

  mbam_resolve u_resolve (
    .cfg(live_if.dst),
    .i_addr(I_FRM_ADDR),
    .i_func(I_FRM_FUNC),
    .i_reg(I_FRM_REG),
    .i_qty(I_FRM_QTY),
    .i_ascii(I_FRM_ASCII),
    .o_hit(frm_hit),
    .o_range_ok(frm_range_ok),
    .o_unit(frm_unit),
    .o_offs(frm_offs),
    .o_exc(frm_exc)
  );

  wire take = I_FRM_VALID && frm_hit;
  wire drop = I_FRM_VALID && !frm_hit;

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_RSP_VALID <= 1'b0;
      O_RSP_DROP <= 1'b0;
      O_RSP_UNIT <= 7'h00;
      O_RSP_OFFS <= 4'h0;
      O_RSP_EXC <= mbam_pkg::EXC_NONE;
    end else begin
      O_RSP_VALID <= take;
      O_RSP_DROP <= drop;
      if (take) begin
        O_RSP_UNIT <= frm_unit;
        O_RSP_OFFS <= frm_offs;
        O_RSP_EXC <= frm_exc;
      end
    end
  end

  // Counters wrap; they only track traffic for software
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      served_ff <= 16'h0000;
      dropped_ff <= 16'h0000;
    end else begin
      served_ff <= served_ff + {15'h0000, take};
      dropped_ff <= dropped_ff + {15'h0000, drop};
    end
  end

  // ----------------------------------------------------------------
  // Serial framing
  // ----------------------------------------------------------------
  wire [15:0] nxt_div = (baud_ff == 3'h0) ? mbam_pkg::DIV_A :
                        (baud_ff == 3'h1) ? mbam_pkg::DIV_B :
                        (baud_ff == 3'h2) ? mbam_pkg::DIV_C :
                        (baud_ff == 3'h3) ? mbam_pkg::DIV_D :
                        mbam_pkg::DIV_E;

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_BIT_DIV <= mbam_pkg::DIV_B;
      O_DATA_BITS <= mbam_pkg::DATA_BITS;
      O_PARITY_EN <= 1'b1;
      O_PARITY_ODD <= 1'b0;
      O_STOP_TWO <= 1'b0;
    end else begin
      O_BIT_DIV <= nxt_div;
      O_DATA_BITS <= mbam_pkg::DATA_BITS;
      O_PARITY_EN <= par_ff != mbam_pkg::MBAM_PAR_NONE;
      O_PARITY_ODD <= par_ff == mbam_pkg::MBAM_PAR_ODD;
      O_STOP_TWO <= par_ff == mbam_pkg::MBAM_PAR_NONE;
    end
  end

  assign O_PRDATA = rdata_ff;
  assign O_PREADY = ready_ff;
  assign O_PSLVERR = err_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_NRST);

  a_hi_range: assert property (hi_ff >= 7'h01 && hi_ff <= 7'h64)
    else $error("highest remote index out of range");
  a_sid_range: assert property (sid_ff >= 8'h01 && sid_ff <= 8'hf7)
    else $error("station address out of range");
  a_sid_ceiling: assert property (
    mode_ff == mbam_pkg::MBAM_MAP_ADDR |->
      ({1'b0, sid_ff} + {2'b00, hi_ff}) <= 9'h0f7)
    else $error("mapped remote address above 247");
  a_reset_ids: assert property (
    $rose(I_NRST) |-> hi_ff == 7'h01 && sid_ff == 8'h01)
    else $error("index or station address not one after reset");
  a_reset_link: assert property (
    $rose(I_NRST) |-> baud_ff == 3'h1 &&
      par_ff == mbam_pkg::MBAM_PAR_EVEN &&
      mode_ff == mbam_pkg::MBAM_MAP_ADDR)
    else $error("rate, parity or mode wrong after reset");
  a_remote_addr: assert property (
    O_RSP_VALID && $past(mode_ff) == mbam_pkg::MBAM_MAP_ADDR &&
      O_RSP_UNIT != 7'h00 |->
      $past(I_FRM_ADDR) == $past(sid_ff) + {1'b0, O_RSP_UNIT})
    else $error("remote unit answered at wrong address");
  a_excluded_unit: assert property (
    I_FRM_VALID && mode_ff == mbam_pkg::MBAM_MAP_ADDR &&
      I_FRM_ADDR > sid_ff && (I_FRM_ADDR - sid_ff) > {1'b0, hi_ff}
      |=> !O_RSP_VALID && O_RSP_DROP)
    else $error("remote above highest index was served");
  a_reg_mode_addr: assert property (
    I_FRM_VALID && mode_ff == mbam_pkg::MBAM_MAP_REG &&
      I_FRM_ADDR != sid_ff |=> !O_RSP_VALID)
    else $error("register mode answered a foreign address");
  a_ascii_refused: assert property (
    I_FRM_VALID && I_FRM_ASCII |=> O_RSP_DROP && !O_RSP_VALID)
    else $error("ASCII frame was accepted");
  a_reg_block: assert property (
    O_RSP_VALID && $past(mode_ff) == mbam_pkg::MBAM_MAP_REG &&
      O_RSP_EXC == 8'h00 && $past(I_FRM_FUNC) == 8'h03 |->
      $past(I_FRM_REG) == 16'(O_RSP_UNIT) * 16'h000a +
        16'(O_RSP_OFFS) + 16'h0001)
    else $error("register number maps to wrong unit block");
  a_illegal_addr: assert property (
    take && I_FRM_FUNC == 8'h03 && !frm_range_ok |=>
      O_RSP_VALID && O_RSP_EXC == 8'h02)
    else $error("unmapped read gave no exception two");
  a_stop_bits: assert property (
    ##1 O_STOP_TWO == ($past(par_ff) == mbam_pkg::MBAM_PAR_NONE) &&
      O_PARITY_EN == !O_STOP_TWO)
    else $error("stop bits do not follow parity");
  a_apb_ready: assert property (setup |=> O_PREADY ##1 !O_PREADY)
    else $error("APB ready not a single access cycle");

  c_remote_hit: cover property (O_RSP_VALID && O_RSP_UNIT != 7'h00 &&
    mode_ff == mbam_pkg::MBAM_MAP_ADDR);
  c_reg_mode_hit: cover property (O_RSP_VALID && O_RSP_UNIT != 7'h00 &&
    mode_ff == mbam_pkg::MBAM_MAP_REG);
  c_exception: cover property (O_RSP_VALID && O_RSP_EXC == 8'h02);
  c_rejected: cover property (cfg_rej);
endmodule : mbam_top
`default_nettype wire

// ==== rtl/mbam_pkg.sv ====
// Shared constants and types for the Modbus address mapper
package mbam_pkg;
  // ----------------------------------------------------------------
  // Register map and field layout
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_CFG = 12'h000;
  localparam logic [11:0] ADDR_STAT = 12'h004;
  localparam logic [11:0] ADDR_SERVED = 12'h008;
  localparam logic [11:0] ADDR_DROPPED = 12'h00c;
  localparam int CFG_HI_LSB = 0;
  localparam int CFG_SID_LSB = 8;
  localparam int CFG_BAUD_LSB = 16;
  localparam int CFG_PAR_LSB = 20;
  localparam int CFG_MODE_BIT = 24;
  localparam int STAT_REJ_BIT = 0;
  localparam int STAT_WHY_LSB = 4;
  localparam int STAT_CEIL_LSB = 8;
  // ----------------------------------------------------------------
  // Setting limits and reset values
  // ----------------------------------------------------------------
  localparam logic [6:0] HI_MIN = 7'h01;
  localparam logic [6:0] HI_MAX = 7'h64;
  localparam logic [7:0] SID_MIN = 8'h01;
  localparam logic [7:0] SID_MAX = 8'hf7;
  localparam logic [2:0] BAUD_SEL_MAX = 3'h4;
  localparam logic [6:0] RST_HI = 7'h01;
  localparam logic [7:0] RST_SID = 8'h01;
  localparam logic [2:0] RST_BAUD = 3'h1;
  localparam logic [3:0] REGS_PER_UNIT = 4'ha;
  localparam logic [7:0] FUNC_READ_HOLD = 8'h03;
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_ILL_ADDR = 8'h02;
  // Reasons a configuration write was refused
  localparam logic [2:0] WHY_OK = 3'h0;
  localparam logic [2:0] WHY_HI = 3'h1;
  localparam logic [2:0] WHY_SID = 3'h2;
  localparam logic [2:0] WHY_CEIL = 3'h3;
  localparam logic [2:0] WHY_BAUD = 3'h4;
  localparam logic [2:0] WHY_PAR = 3'h5;
  // ----------------------------------------------------------------
  // Serial timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 100_000_000;
  localparam int BAUD_A = 9600;
  localparam int BAUD_B = 19200;
  localparam int BAUD_C = 38400;
  localparam int BAUD_D = 57600;
  localparam int BAUD_E = 115200;
  localparam logic [15:0] DIV_A = 16'(CLK_HZ / BAUD_A);
  localparam logic [15:0] DIV_B = 16'(CLK_HZ / BAUD_B);
  localparam logic [15:0] DIV_C = 16'(CLK_HZ / BAUD_C);
  localparam logic [15:0] DIV_D = 16'(CLK_HZ / BAUD_D);
  localparam logic [15:0] DIV_E = 16'(CLK_HZ / BAUD_E);
  localparam logic [3:0] DATA_BITS = 4'h8;

  typedef enum logic [1:0] {
    MBAM_PAR_NONE = 2'h0,
    MBAM_PAR_EVEN = 2'h1,
    MBAM_PAR_ODD = 2'h2
  } mbam_par_t;

  typedef enum logic {
    MBAM_MAP_ADDR = 1'b0,
    MBAM_MAP_REG = 1'b1
  } mbam_map_t;
endpackage : mbam_pkg

// ==== rtl/mbam_cfg_if.sv ====
// Mapping settings carried between the mapper's own modules
`timescale 1ns/1ns
`default_nettype none
interface mbam_cfg_if;
  logic [6:0] highest_remote_index;
  logic [7:0] station_address;
  mbam_pkg::mbam_map_t map_mode_select;
  modport src (output highest_remote_index, station_address, map_mode_select);
  modport dst (input highest_remote_index, station_address, map_mode_select);
endinterface : mbam_cfg_if
`default_nettype wire

// ==== rtl/mbam_cfg_check.sv ====
// Legality check of a proposed set of mapping and link settings
`timescale 1ns/1ns
`default_nettype none
module mbam_cfg_check (
  mbam_cfg_if.dst cand,          // Proposed mapping settings
  input wire logic [2:0] i_baud, // Proposed serial rate select
  input wire logic [1:0] i_par,  // Proposed parity select
  output logic o_ok,             // Settings are legal
  output logic [2:0] o_why       // Refusal reason
);
  wire [8:0] sum_w = {1'b0, cand.station_address} +
                     {2'b00, cand.highest_remote_index};
  wire hi_bad = cand.highest_remote_index < mbam_pkg::HI_MIN ||
                cand.highest_remote_index > mbam_pkg::HI_MAX;
  wire sid_bad = cand.station_address < mbam_pkg::SID_MIN ||
                 cand.station_address > mbam_pkg::SID_MAX;
  // Every mapped remote address must stay legal
  wire ceil_bad = cand.map_mode_select == mbam_pkg::MBAM_MAP_ADDR &&
                  sum_w > {1'b0, mbam_pkg::SID_MAX};
  wire baud_bad = i_baud > mbam_pkg::BAUD_SEL_MAX;
  wire par_bad = i_par > 2'(mbam_pkg::MBAM_PAR_ODD);
  assign o_ok = !(hi_bad || sid_bad || ceil_bad || baud_bad || par_bad);
  assign o_why = hi_bad ? mbam_pkg::WHY_HI :
                 sid_bad ? mbam_pkg::WHY_SID :
                 ceil_bad ? mbam_pkg::WHY_CEIL :
                 baud_bad ? mbam_pkg::WHY_BAUD :
                 par_bad ? mbam_pkg::WHY_PAR : mbam_pkg::WHY_OK;
endmodule : mbam_cfg_check
`default_nettype wire

// ==== rtl/mbam_resolve.sv ====
// Slave address and holding register resolution for one frame
`timescale 1ns/1ns
`default_nettype none
module mbam_resolve (
  mbam_cfg_if.dst cfg,            // Live mapping settings
  input wire logic [7:0] i_addr,  // Frame slave address
  input wire logic [7:0] i_func,  // Frame function code
  input wire logic [15:0] i_reg,  // First register number, 1-based
  input wire logic [15:0] i_qty,  // Register count
  input wire logic i_ascii,       // Frame arrived in ASCII mode
  output logic o_hit,             // Frame is ours
  output logic o_range_ok,        // Requested registers are mapped
  output logic [6:0] o_unit,      // 0 for the station, else remote
  output logic [3:0] o_offs,      // Register offset within unit
  output logic [7:0] o_exc        // Exception code, 0 if none
);
  wire addr_mode = cfg.map_mode_select == mbam_pkg::MBAM_MAP_ADDR;
  wire own = i_addr == cfg.station_address;
  wire [7:0] diff = i_addr - cfg.station_address;
  // Units above the highest index get no address at all
  wire remote = addr_mode && i_addr > cfg.station_address &&
                diff <= {1'b0, cfg.highest_remote_index};
  // Only binary framing is served; others stay silent
  assign o_hit = !i_ascii && (own || remote);
  wire [16:0] last = {1'b0, i_reg} + {1'b0, i_qty} - 17'h00001;
  wire [10:0] top = 11'({4'h0, cfg.highest_remote_index} + 11'h001) *
                    11'(mbam_pkg::REGS_PER_UNIT);
  wire [16:0] lim = addr_mode ? 17'(mbam_pkg::REGS_PER_UNIT) : 17'(top);
  assign o_range_ok = i_qty != 16'h0000 && i_reg != 16'h0000 &&
                      last <= lim;
  // Divide by ten through a reciprocal; exact for all mapped numbers
  wire [9:0] idx = 10'(i_reg - 16'h0001);
  wire [19:0] prod = 20'(idx) * 20'd205;
  wire [6:0] blk = 7'(prod[19:11]);
  wire [9:0] blk_base = 10'(blk) * 10'(mbam_pkg::REGS_PER_UNIT);
  assign o_unit = addr_mode ? (own ? 7'h00 : diff[6:0]) : blk;
  assign o_offs = addr_mode ? 4'(idx) : 4'(idx - blk_base);
  // Read holding registers is the only function range-checked here
  assign o_exc = (i_func == mbam_pkg::FUNC_READ_HOLD && !o_range_ok) ?
                 mbam_pkg::EXC_ILL_ADDR : mbam_pkg::EXC_NONE;
endmodule : mbam_resolve
`default_nettype wire

// ==== test/mbam_master_model.sv ====
// Behavioural Modbus RTU master handing parsed frames to the mapper
`timescale 1ns/1ns
`default_nettype none
module mbam_master_model (
  input wire logic i_clk,     // Device clock
  output logic o_valid,       // Frame strobe
  output logic [7:0] o_addr,  // Slave address
  output logic [7:0] o_func,  // Function code
  output logic [15:0] o_reg,  // First register, 1-based
  output logic [15:0] o_qty,  // Register count
  output logic o_ascii        // ASCII framing used
);
  // Function code of the next frame; the bench may pick another one
  logic [7:0] fn = mbam_pkg::FUNC_READ_HOLD;

  initial begin
    o_valid = 1'b0;
    {o_addr, o_func, o_reg, o_qty, o_ascii} = '0;
  end

  // Fields are inverted once the strobe drops, so stale values never match
  task automatic send(input logic [7:0] a, input logic [15:0] r,
                      input logic [15:0] q, input logic asc);
    @(posedge i_clk);
    o_valid <= 1'b1;
    o_addr <= a;
    o_func <= fn;
    o_reg <= r;
    o_qty <= q;
    o_ascii <= asc;
    @(posedge i_clk);
    o_valid <= 1'b0;
    o_addr <= ~a;
    o_func <= ~fn;
    o_reg <= ~r;
    o_qty <= ~q;
    o_ascii <= ~asc;
  endtask : send
endmodule : mbam_master_model
`default_nettype wire

// ==== test/mbam_top_test.sv ====
// Self-checking bench for the Modbus address mapper
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e, m) begin n_tests++; if ((g) !== (e)) begin failures++; \
  $display("mismatch at %0t: %s", $time, m); end end
module mbam_top_test;
  logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, err, fv, fa, rv, rdp, pen, podd, stwo;
  logic [7:0] faddr, ffunc, rexc;
  logic [15:0] freg, fqty, div;
  logic [6:0] runit;
  logic [3:0] roffs, dbits;
  logic [15:0] divs [5] = '{mbam_pkg::DIV_A, mbam_pkg::DIV_B,
    mbam_pkg::DIV_C, mbam_pkg::DIV_D, mbam_pkg::DIV_E};
  int failures = 0, n_tests = 0, cycles = 0, n_srv = 0, n_drp = 0;

  always #5 clk = ~clk;

  mbam_master_model mm_u (.i_clk(clk), .o_valid(fv), .o_addr(faddr),
    .o_func(ffunc), .o_reg(freg), .o_qty(fqty), .o_ascii(fa));
  mbam_top dut_u (.I_CLK(clk), .I_NRST(nrst), .I_PSEL(psel),
    .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr),
    .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .I_FRM_VALID(fv), .I_FRM_ADDR(faddr),
    .I_FRM_FUNC(ffunc), .I_FRM_REG(freg), .I_FRM_QTY(fqty),
    .I_FRM_ASCII(fa), .O_RSP_VALID(rv), .O_RSP_DROP(rdp),
    .O_RSP_UNIT(runit), .O_RSP_OFFS(roffs), .O_RSP_EXC(rexc),
    .O_BIT_DIV(div), .O_DATA_BITS(dbits), .O_PARITY_EN(pen),
    .O_PARITY_ODD(podd), .O_STOP_TWO(stwo));

  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : give_verdict

  // A hang stops the run rather than stalling the regression
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      give_verdict();
    end
  end

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic exp_err);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait for ready
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    `CHK(err, exp_err, "error response")
  endtask : apb

  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, '0, 1'b0);
    `CHK(rd, e, "read data")
  endtask : rchk

  function automatic logic [31:0] cw(input logic [6:0] h, input logic [7:0] s,
                                     input logic [2:0] b, input logic [1:0] p,
                                     input logic m);
    cw = (32'(h) << mbam_pkg::CFG_HI_LSB) | (32'(s) << mbam_pkg::CFG_SID_LSB)
      | (32'(b) << mbam_pkg::CFG_BAUD_LSB) | (32'(p) << mbam_pkg::CFG_PAR_LSB)
      | (32'(m) << mbam_pkg::CFG_MODE_BIT);
  endfunction : cw

  function automatic logic [31:0] st(input logic [2:0] why, input logic [7:0] c);
    st = (32'(c) << mbam_pkg::STAT_CEIL_LSB) | (32'(why) << 4) | 32'h1;
  endfunction : st

  task automatic frm(input logic [7:0] a, input logic [15:0] r,
                     input logic [15:0] q, input logic asc, input logic hit,
                     input logic [6:0] u, input logic [3:0] o,
                     input logic [7:0] e);
    mm_u.send(a, r, q, asc);
    @(posedge clk);
    `CHK(rv, hit, "accept pulse")
    `CHK(rdp, ~hit, "drop pulse")
    if (hit) n_srv++;
    else n_drp++;
    if (hit) `CHK(rexc, e, "exception code")
    if (hit && e == mbam_pkg::EXC_NONE) begin
      `CHK(runit, u, "unit")
      `CHK(roffs, o, "offset")
    end
  endtask : frm

  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    rchk(mbam_pkg::ADDR_CFG, 32'h0011_0101);
    `CHK(div, mbam_pkg::DIV_B, "reset rate")
    `CHK({dbits, pen, podd, stwo}, 7'h44, "reset framing")
    frm(8'h01, 16'h0001, 16'h0002, 1'b0, 1'b1, 7'h00, 4'h0, 8'h00);
    frm(8'h02, 16'h000a, 16'h0001, 1'b0, 1'b1, 7'h01, 4'h9, 8'h00);
    frm(8'h02, 16'h000b, 16'h0001, 1'b0, 1'b1, 7'h01, 4'h0, 8'h02);
    frm(8'h01, 16'h0000, 16'h0001, 1'b0, 1'b1, 7'h00, 4'h0, 8'h02);
    frm(8'h01, 16'h0005, 16'h0000, 1'b0, 1'b1, 7'h00, 4'h0, 8'h02);
    frm(8'h03, 16'h0001, 16'h0001, 1'b0, 1'b0, 7'h00, 4'h0, 8'h00);
    frm(8'h01, 16'h0001, 16'h0001, 1'b1, 1'b0, 7'h00, 4'h0, 8'h00);
    apb(1'b1, mbam_pkg::ADDR_CFG, cw(7'd100, 8'd147, 3'h1, 2'h1, 1'b0), 1'b0);
    frm(8'd247, 16'h0003, 16'h0001, 1'b0, 1'b1, 7'd100, 4'h2, 8'h00);
    frm(8'd146, 16'h0001, 16'h0001, 1'b0, 1'b0, 7'h00, 4'h0, 8'h00);
    apb(1'b1, mbam_pkg::ADDR_CFG, cw(7'd101, 8'd1, 3'h1, 2'h1, 1'b0), 1'b1);
    rchk(mbam_pkg::ADDR_STAT, st(mbam_pkg::WHY_HI, 8'd147));
    apb(1'b1, mbam_pkg::ADDR_CFG, cw(7'd0, 8'd1, 3'h1, 2'h1, 1'b0), 1'b1);
    apb(1'b1, mbam_pkg::ADDR_CFG, cw(7'd100, 8'd148, 3'h1, 2'h1, 1'b0), 1'b1);
    rchk(mbam_pkg::ADDR_STAT, st(mbam_pkg::WHY_CEIL, 8'd147));
    rchk(mbam_pkg::ADDR_CFG, cw(7'd100, 8'd147, 3'h1, 2'h1, 1'b0));
    apb(1'b1, mbam_pkg::ADDR_STAT, 32'h1, 1'b0);
    // Clearing the flag leaves the last reason in place
    rchk(mbam_pkg::ADDR_STAT, st(mbam_pkg::WHY_CEIL, 8'd147) ^ 32'h1);
    apb(1'b1, mbam_pkg::ADDR_CFG, cw(7'd3, 8'd247, 3'h1, 2'h1, 1'b1), 1'b0);
    frm(8'd247, 16'd31, 16'h0001, 1'b0, 1'b1, 7'h03, 4'h0, 8'h00);
    frm(8'd247, 16'd30, 16'h0001, 1'b0, 1'b1, 7'h02, 4'h9, 8'h00);
    frm(8'd247, 16'd40, 16'h0002, 1'b0, 1'b1, 7'h00, 4'h0, 8'h02);
    frm(8'd248, 16'h0001, 16'h0001, 1'b0, 1'b0, 7'h00, 4'h0, 8'h00);
    apb(1'b1, mbam_pkg::ADDR_CFG, cw(7'd3, 8'd248, 3'h1, 2'h1, 1'b1), 1'b1);
    apb(1'b1, mbam_pkg::ADDR_CFG, cw(7'd3, 8'd0, 3'h1, 2'h1, 1'b1), 1'b1);
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, mbam_pkg::ADDR_CFG, cw(7'd1, 8'd1, 3'(i), 2'h1, 1'b0), 1'b0);
      repeat (2) @(posedge clk);
      `CHK(div, divs[i], "bit divider")
    end
    apb(1'b1, mbam_pkg::ADDR_CFG, cw(7'd1, 8'd1, 3'h5, 2'h1, 1'b0), 1'b1);
    for (int p = 0; p < 3; p++) begin
      apb(1'b1, mbam_pkg::ADDR_CFG, cw(7'd1, 8'd1, 3'h1, 2'(p), 1'b0), 1'b0);
      repeat (2) @(posedge clk);
      `CHK({pen, podd, stwo}, {p != 0, p == 2, p == 0}, "framing")
    end
    apb(1'b1, mbam_pkg::ADDR_CFG, cw(7'd1, 8'd1, 3'h1, 2'h3, 1'b0), 1'b1);
    // Other functions are served here without an address exception
    mm_u.fn = 8'h08;
    frm(8'h01, 16'h0003, 16'h0000, 1'b0, 1'b1, 7'h00, 4'h2, 8'h00);
    mm_u.fn = mbam_pkg::FUNC_READ_HOLD;
    apb(1'b0, 12'h010, '0, 1'b1);
    apb(1'b1, mbam_pkg::ADDR_SERVED, 32'h0, 1'b1);
    rchk(mbam_pkg::ADDR_SERVED, 32'(n_srv));
    rchk(mbam_pkg::ADDR_DROPPED, 32'(n_drp));
    give_verdict();
  end
endmodule : mbam_top_test
`default_nettype wire
